// >>> hdl/rtd_pkg.sv
package rtd_pkg;

   // ***************************************************
   // Opcodes of the transfer group
   // ***************************************************
   localparam logic [9:0] OP_TMR1     = 10'h24b;
   localparam logic [9:0] OP_TMR2     = 10'h24c;
   localparam logic [9:0] OP_TMR3     = 10'h24d;
   localparam logic [9:0] OP_TMR4     = 10'h24e;
   localparam logic [9:0] OP_TMR5     = 10'h24f;
   localparam logic [9:0] OP_IDX_ACC  = 10'h053;
   localparam logic [9:0] OP_ACC_HIGH = 10'h00e;
   localparam logic [9:0] OP_ACC_PTR  = 10'h029;
   localparam logic [9:0] OP_PAIR     = 10'h01a;
   localparam logic [9:0] OP_PORT0    = 10'h228;
   localparam logic [9:0] OP_PORT1    = 10'h229;
   localparam logic [9:0] OP_PORT2    = 10'h22a;
   localparam logic [9:0] OP_PORT3    = 10'h22b;

   // ***************************************************
   // Register map, byte addresses
   // ***************************************************
   localparam logic [5:0] ADR_ACC    = 6'h00;
   localparam logic [5:0] ADR_HIGH   = 6'h04;
   localparam logic [5:0] ADR_PTR    = 6'h08;
   localparam logic [5:0] ADR_BYTE   = 6'h0c;
   localparam logic [5:0] ADR_PORT   = 6'h10;
   localparam logic [5:0] ADR_CTRL   = 6'h14;
   localparam logic [5:0] ADR_STATUS = 6'h18;

   localparam int         CTRL_EN_BIT  = 0;
   localparam logic       CTRL_EN_RST  = 1'b1;
   localparam int         STAT_HIT_BIT = 0;
   localparam int         STAT_MISS_BIT = 1;
   localparam logic [3:0] ACC_RST     = 4'h0;
   localparam logic [1:0] ZERO2       = 2'h0;
   localparam logic [0:0] ZERO1       = 1'h0;

   // ***************************************************
   // Carriers
   // ***************************************************
   typedef struct packed {
      logic [3:0] tc5;
      logic [3:0] tc4;
      logic [3:0] tc3;
      logic [3:0] tc2;
      logic [3:0] tc1;
   } rtd_timer_ctl_type;

   typedef struct packed {
      logic [3:0] ps3;
      logic [3:0] ps2;
      logic [3:0] ps1;
      logic [3:0] ps0;
   } rtd_port_struct_type;

   localparam rtd_port_struct_type PORT_RST = 16'h0000;

   typedef enum logic [1:0] {
      RTD_CLS_NONE,
      RTD_CLS_ACC,
      RTD_CLS_OTHER
   } rtd_class_type;

endpackage

// >>> hdl/rtd_decode.sv
// Function
// - Opcode 0x24b copies timer control 1 into the accumulator.
// - Opcode 0x24c copies timer control 2 into the accumulator, nothing else.
// - Opcode 0x24d copies timer control 3 into the accumulator, nothing else.
// - Opcode 0x24e copies timer control 4 into the accumulator.
// - Opcode 0x053 puts the two index bits into accumulator bits 1 and 0.
// - Index-to-accumulator transfer forces accumulator bits 3 and 2 to zero.
// - Opcode 0x00e copies the accumulator into the high nibble register.
// - Opcode 0x029 copies accumulator bits 2..0 into the pointer register.
// - Opcode 0x01a loads byte register: high nibble over accumulator.
// - Opcodes 0x228..0x22b load the accumulator into port structure 0..3.
module rtd_decode
   import rtd_pkg::*;
(
   input  wire logic                clk_in,
   input  wire logic                rst_in,
   input  wire logic                instr_valid_in,
   input  wire logic [9:0]          instr_in,
   input  wire rtd_timer_ctl_type   timer_ctl_in,
   input  wire logic [1:0]          index_in,
   input  wire logic [5:0]          avs_address_in,
   input  wire logic                avs_read_in,
   input  wire logic                avs_write_in,
   input  wire logic [31:0]         avs_writedata_in,
   input  wire logic [3:0]          avs_byteenable_in,
   output logic [31:0]              avs_readdata_out,
   output logic                     avs_waitrequest_out,
   output logic [3:0]               acc_out,
   output logic [3:0]               high_nibble_out,
   output logic [2:0]               pointer_out,
   output logic [7:0]               byte_reg_out,
   output rtd_port_struct_type      port_struct_out,
   output logic                     done_out,
   output logic                     carry_we_out,
   output logic                     skip_out
);

   // ***************************************************
   // Decode
   // ***************************************************
   function automatic rtd_class_type op_class(input logic [9:0] op);
      if ((op >= OP_TMR1 && op <= OP_TMR5) || op == OP_IDX_ACC)
         return RTD_CLS_ACC;
      else if (op == OP_ACC_HIGH || op == OP_ACC_PTR || op == OP_PAIR
               || (op >= OP_PORT0 && op <= OP_PORT3))
         return RTD_CLS_OTHER;
      else
         return RTD_CLS_NONE;
   endfunction

   logic                ctrl_en_r;
   logic [3:0]          acc_r;
   logic [3:0]          acc_nxt;
   logic [3:0]          high_r;
   logic [2:0]          ptr_r;
   logic [7:0]          byte_r;
   rtd_port_struct_type port_r;
   rtd_port_struct_type port_nxt;
   logic                done_r;
   logic                hit_r;
   logic                miss_r;
   logic                wait_r;
   logic [31:0]         rdata_r;

   wire                 exec      = instr_valid_in & ctrl_en_r;
   wire rtd_class_type  cls       = op_class(instr_in);
   wire                 hit       = exec && (cls != RTD_CLS_NONE);
   wire                 acc_load  = exec && (cls == RTD_CLS_ACC);
   wire                 op_high   = exec && (instr_in == OP_ACC_HIGH);
   wire                 op_ptr    = exec && (instr_in == OP_ACC_PTR);
   wire                 op_pair   = exec && (instr_in == OP_PAIR);
   wire                 op_port0  = exec && (instr_in == OP_PORT0);
   wire                 op_port1  = exec && (instr_in == OP_PORT1);
   wire                 op_port2  = exec && (instr_in == OP_PORT2);
   wire                 op_port3  = exec && (instr_in == OP_PORT3);

   // ***************************************************
   // Bus decode
   // ***************************************************
   wire                 bus_req   = avs_read_in | avs_write_in;
   wire                 bus_go    = bus_req & ~wait_r;
   wire                 wr_lane0  = bus_go & avs_write_in & avs_byteenable_in[0];
   wire                 sw_acc_wr = wr_lane0 && (avs_address_in == ADR_ACC);
   wire                 sw_ctl_wr = wr_lane0 && (avs_address_in == ADR_CTRL);

   // Instruction result is selected here; a bus write to the accumulator in
   // the same cycle loses, so the core never sees a half-done transfer
   always_comb begin
      acc_nxt = acc_r;
      if (sw_acc_wr) begin
         acc_nxt = avs_writedata_in[3:0];
      end
      unique case (instr_in)
         OP_TMR1:    if (acc_load) acc_nxt = timer_ctl_in.tc1;
         OP_TMR2:    if (acc_load) acc_nxt = timer_ctl_in.tc2;
         OP_TMR3:    if (acc_load) acc_nxt = timer_ctl_in.tc3;
         OP_TMR4:    if (acc_load) acc_nxt = timer_ctl_in.tc4;
         OP_TMR5:    if (acc_load) acc_nxt = timer_ctl_in.tc5;
         OP_IDX_ACC: if (acc_load) acc_nxt = {ZERO2, index_in};
         default:    ;
      endcase
   end

   always_comb begin
      port_nxt = port_r;
      if (op_port0) port_nxt.ps0 = acc_r;
      if (op_port1) port_nxt.ps1 = acc_r;
      if (op_port2) port_nxt.ps2 = acc_r;
      if (op_port3) port_nxt.ps3 = acc_r;
   end

   // ***************************************************
   // Core register updates
   // ***************************************************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         acc_r  <= ACC_RST;
         high_r <= ACC_RST;
         ptr_r  <= 3'h0;
         byte_r <= 8'h00;
         port_r <= PORT_RST;
      end else begin
         acc_r  <= acc_nxt;
         port_r <= port_nxt;
         if (op_high) high_r <= acc_r;
         if (op_ptr)  ptr_r  <= acc_r[2:0];
         if (op_pair) byte_r <= {high_r, acc_r};
      end
   end

   // Every transfer retires in the cycle after it is presented while the control enable bit is set
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         done_r <= 1'b0;
         hit_r  <= 1'b0;
         miss_r <= 1'b0;
      end else begin
         done_r <= hit;
         if (exec) begin
            hit_r  <= hit;
            miss_r <= ~hit;
         end
      end
   end

   // ***************************************************
   // Avalon slave: one wait state on every access
   // ***************************************************
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address_in)
         ADR_ACC:    rd_mux[3:0]  = acc_r;
         ADR_HIGH:   rd_mux[3:0]  = high_r;
         ADR_PTR:    rd_mux[2:0]  = ptr_r;
         ADR_BYTE:   rd_mux[7:0]  = byte_r;
         ADR_PORT:   rd_mux[15:0] = port_r;
         ADR_CTRL:   rd_mux[CTRL_EN_BIT] = ctrl_en_r;
         ADR_STATUS: begin
            rd_mux[STAT_HIT_BIT]  = hit_r;
            rd_mux[STAT_MISS_BIT] = miss_r;
         end
         default:    rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wait_r    <= 1'b1;
         rdata_r   <= 32'h0000_0000;
         ctrl_en_r <= CTRL_EN_RST;
      end else begin
         wait_r <= ~(bus_req & wait_r);
         if (bus_req & wait_r & avs_read_in) rdata_r <= rd_mux;
         if (sw_ctl_wr) ctrl_en_r <= avs_writedata_in[CTRL_EN_BIT];
      end
   end

   assign avs_readdata_out    = rdata_r;
   assign avs_waitrequest_out = wait_r;
   assign acc_out             = acc_r;
   assign high_nibble_out     = high_r;
   assign pointer_out         = ptr_r;
   assign byte_reg_out        = byte_r;
   assign port_struct_out     = port_r;
   assign done_out            = done_r;

   // Group never writes carry nor requests a skip; held in flops for timing
   logic zero_r;
   always_ff @(posedge clk_in) begin
      zero_r <= ZERO1;
   end
   assign carry_we_out = zero_r;
   assign skip_out     = zero_r;

   // ***************************************************
   // Checks
   // ***************************************************
   property p_tmr1;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_TMR1) |=> acc_out == $past(timer_ctl_in.tc1);
   endproperty
   a_tmr1: assert property (p_tmr1) else $error("acc not loaded from tc1");

   property p_tmr2;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_TMR2)
         |=> acc_out == $past(timer_ctl_in.tc2) && $stable(high_nibble_out)
             && $stable(pointer_out) && $stable(byte_reg_out);
   endproperty
   a_tmr2: assert property (p_tmr2) else $error("tc2 read wrong");

   property p_tmr3;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_TMR3)
         |=> acc_out == $past(timer_ctl_in.tc3) && $stable(port_struct_out);
   endproperty
   a_tmr3: assert property (p_tmr3) else $error("tc3 read wrong");

   property p_tmr4;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_TMR4) |=> acc_out == $past(timer_ctl_in.tc4);
   endproperty
   a_tmr4: assert property (p_tmr4) else $error("acc not loaded from tc4");

   property p_tmr5;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_TMR5) |=> acc_out == $past(timer_ctl_in.tc5);
   endproperty
   a_tmr5: assert property (p_tmr5) else $error("acc not loaded from tc5");

   property p_idx_low;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_IDX_ACC) |=> acc_out[1:0] == $past(index_in);
   endproperty
   a_idx_low: assert property (p_idx_low) else $error("index bits wrong");

   property p_idx_high;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_IDX_ACC) |=> acc_out[3:2] == ZERO2;
   endproperty
   a_idx_high: assert property (p_idx_high) else $error("upper acc not zero");

   property p_high;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_ACC_HIGH && !sw_acc_wr)
         |=> high_nibble_out == $past(acc_out) && $stable(acc_out);
   endproperty
   a_high: assert property (p_high) else $error("high nibble copy wrong");

   property p_ptr;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_ACC_PTR) |=> pointer_out == $past(acc_out[2:0]);
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer copy wrong");

   property p_pair;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_PAIR)
         |=> byte_reg_out == {$past(high_nibble_out), $past(acc_out)};
   endproperty
   a_pair: assert property (p_pair) else $error("byte register wrong");

   property p_port;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_PORT3) ##1 (exec && instr_in == OP_PORT0)
         |=> port_struct_out.ps3 == $past(acc_out, 2)
             && port_struct_out.ps0 == $past(acc_out);
   endproperty
   a_port: assert property (p_port) else $error("port structure load wrong");

   property p_one_cycle;
      @(posedge clk_in) disable iff (rst_in)
      hit |=> done_out && !carry_we_out && !skip_out ##1 (done_out == $past(hit));
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("retire timing wrong");

   property p_port0;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_PORT0) |=> port_struct_out.ps0 == $past(acc_out);
   endproperty
   a_port0: assert property (p_port0) else $error("port structure 0 wrong");

   property p_port1;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_PORT1) |=> port_struct_out.ps1 == $past(acc_out);
   endproperty
   a_port1: assert property (p_port1) else $error("port structure 1 wrong");

   property p_port2;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_PORT2) |=> port_struct_out.ps2 == $past(acc_out);
   endproperty
   a_port2: assert property (p_port2) else $error("port structure 2 wrong");

   property p_port3;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_PORT3) |=> port_struct_out.ps3 == $past(acc_out);
   endproperty
   a_port3: assert property (p_port3) else $error("port structure 3 wrong");

   // Bus writes to the accumulator are left out: they may land in the same cycle
   property p_port_keep;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in >= OP_PORT0 && instr_in <= OP_PORT3 && !sw_acc_wr)
         |=> $stable(acc_out) && $stable(high_nibble_out);
   endproperty
   a_port_keep: assert property (p_port_keep) else $error("port load disturbed core");

   property p_ptr_keep;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_ACC_PTR && !sw_acc_wr)
         |=> $stable(acc_out) && $stable(high_nibble_out);
   endproperty
   a_ptr_keep: assert property (p_ptr_keep) else $error("pointer copy disturbed acc");

   property p_pair_keep;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_PAIR && !sw_acc_wr)
         |=> $stable(acc_out) && $stable(high_nibble_out) && $stable(pointer_out);
   endproperty
   a_pair_keep: assert property (p_pair_keep) else $error("byte load disturbed core");

   property p_high_keep;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_ACC_HIGH)
         |=> $stable(pointer_out) && $stable(byte_reg_out) && $stable(port_struct_out);
   endproperty
   a_high_keep: assert property (p_high_keep) else $error("high copy disturbed core");

   property p_idx_keep;
      @(posedge clk_in) disable iff (rst_in)
      (exec && instr_in == OP_IDX_ACC)
         |=> $stable(high_nibble_out) && $stable(pointer_out) && $stable(port_struct_out);
   endproperty
   a_idx_keep: assert property (p_idx_keep) else $error("index move disturbed core");

   property p_no_flags;
      @(posedge clk_in) disable iff (rst_in)
      !carry_we_out && !skip_out;
   endproperty
   a_no_flags: assert property (p_no_flags) else $error("carry or skip raised");

   property p_idle_done;
      @(posedge clk_in) disable iff (rst_in)
      !instr_valid_in |=> !done_out;
   endproperty
   a_idle_done: assert property (p_idle_done) else $error("retire without opcode");

   property p_disabled;
      @(posedge clk_in) disable iff (rst_in)
      (instr_valid_in && !ctrl_en_r && !sw_acc_wr)
         |=> $stable(acc_out) && !done_out;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled core executed");

endmodule // rtd_decode

// >>> verification/tb.sv
module tb
   import rtd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************
   // Stimulus and observed signals
   // ***************************************************
   logic                clk_in;
   logic                rst_in;
   logic                instr_valid_in;
   logic [9:0]          instr_in;
   rtd_timer_ctl_type   timer_ctl_in;
   logic [1:0]          index_in;
   logic [5:0]          avs_address_in;
   logic                avs_read_in;
   logic                avs_write_in;
   logic [31:0]         avs_writedata_in;
   logic [3:0]          avs_byteenable_in;
   logic [31:0]         avs_readdata_out;
   logic                avs_waitrequest_out;
   logic [3:0]          acc_out;
   logic [3:0]          high_nibble_out;
   logic [2:0]          pointer_out;
   logic [7:0]          byte_reg_out;
   rtd_port_struct_type port_struct_out;
   logic                done_out;
   logic                carry_we_out;
   logic                skip_out;
   int                  bad_count = 0;
   int                  n_checks = 0;

   rtd_decode rtd_decode_inst (.clk_in(clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
      .instr_in(instr_in), .timer_ctl_in(timer_ctl_in), .index_in(index_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .acc_out(acc_out), .high_nibble_out(high_nibble_out), .pointer_out(pointer_out),
      .byte_reg_out(byte_reg_out), .port_struct_out(port_struct_out), .done_out(done_out),
      .carry_we_out(carry_we_out), .skip_out(skip_out));

   always #10 clk_in = ~clk_in;

   // ***************************************************
   // Shared tasks
   // ***************************************************
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, want, seen);
      end
   endtask

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Holds the request until waitrequest is seen low; bounded so a dead slave ends the run
   task automatic bus(input logic wr, input logic [5:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
      int k;
      @(posedge clk_in);
      avs_read_in      <= !wr;
      avs_write_in     <= wr;
      avs_address_in   <= adr;
      avs_writedata_in <= wd;
      for (k = 0; k < 20; k++) begin
         @(posedge clk_in);
         if (avs_waitrequest_out === 1'b0) break;
      end
      rd = avs_readdata_out;
      avs_read_in  <= 1'b0;
      avs_write_in <= 1'b0;
      if (k == 20) begin
         bad_count++;
         end_sim();
      end
   endtask

   task automatic wr(input logic [5:0] adr, input logic [31:0] wd);
      logic [31:0] d;
      bus(1'b1, adr, wd, d);
   endtask

   task automatic rd(input string name, input logic [5:0] adr, input logic [31:0] want);
      logic [31:0] d;
      bus(1'b0, adr, 32'h0, d);
      chk(name, d, want);
   endtask

   task automatic exec(input logic [9:0] op, input logic want_done);
      @(posedge clk_in);
      instr_valid_in <= 1'b1;
      instr_in       <= op;
      @(posedge clk_in);
      instr_valid_in <= 1'b0;
      #1;
      chk("done", 32'(done_out), 32'(want_done));
      chk("carry_we", 32'(carry_we_out), 32'h0);
      chk("skip", 32'(skip_out), 32'h0);
   endtask

   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_reset();
      chk("acc", 32'(acc_out), 32'h0);
      chk("port", 32'(port_struct_out), 32'h0);
      rd("ctrl", ADR_CTRL, 32'h1);
      $display("reset test done");
   endtask

   task automatic t_timer();
      timer_ctl_in <= 20'hec953;
      for (int i = 0; i < 5; i++) begin
         exec(OP_TMR1 + 10'(i), 1'b1);
         chk("acc_tmr", 32'(acc_out), 32'(timer_ctl_in[4*i +: 4]));
         chk("high_kept", 32'(high_nibble_out), 32'h0);
      end
      @(posedge clk_in);
      #1;
      chk("done_fall", 32'(done_out), 32'h0);
      $display("timer test done");
   endtask

   task automatic t_moves();
      wr(ADR_ACC, 32'hf);
      index_in <= 2'h2;
      exec(OP_IDX_ACC, 1'b1);
      chk("acc_idx", 32'(acc_out), 32'h2);
      wr(ADR_ACC, 32'ha);
      exec(OP_ACC_HIGH, 1'b1);
      chk("high", 32'(high_nibble_out), 32'ha);
      chk("acc_kept", 32'(acc_out), 32'ha);
      wr(ADR_ACC, 32'hd);
      exec(OP_ACC_PTR, 1'b1);
      chk("ptr", 32'(pointer_out), 32'h5);
      exec(OP_PAIR, 1'b1);
      chk("byte", 32'(byte_reg_out), 32'had);
      rd("byte_rd", ADR_BYTE, 32'had);
      $display("move test done");
   endtask

   task automatic t_port();
      logic [15:0] want;
      want = 16'h0;
      for (int i = 0; i < 4; i++) begin
         wr(ADR_ACC, 32'(4'h6 + 4'(i)));
         exec(OP_PORT0 + 10'(i), 1'b1);
         want[4*i +: 4] = 4'h6 + 4'(i);
         chk("port", 32'(port_struct_out), 32'(want));
      end
      $display("port test done");
   endtask

   // Second instruction must see the accumulator written by the first
   task automatic t_b2b();
      @(posedge clk_in);
      instr_valid_in <= 1'b1;
      instr_in       <= OP_TMR4;
      @(posedge clk_in);
      instr_in       <= OP_ACC_HIGH;
      @(posedge clk_in);
      instr_in       <= OP_PORT3;
      @(posedge clk_in);
      instr_in       <= OP_PORT0;
      @(posedge clk_in);
      instr_valid_in <= 1'b0;
      #1;
      chk("b2b_high", 32'(high_nibble_out), 32'hc);
      chk("b2b_done", 32'(done_out), 32'h1);
      chk("b2b_port", 32'(port_struct_out), 32'hc87c);
      $display("back to back test done");
   endtask

   task automatic t_refuse();
      exec(10'h3ff, 1'b0);
      chk("acc_refused", 32'(acc_out), 32'hc);
      rd("status", ADR_STATUS, 32'h2);
      rd("unmapped", 6'h3c, 32'h0);
      wr(ADR_HIGH, 32'h5);
      rd("high_ro", ADR_HIGH, 32'hc);
      wr(ADR_CTRL, 32'h0);
      exec(OP_TMR2, 1'b0);
      chk("acc_disabled", 32'(acc_out), 32'hc);
      wr(ADR_CTRL, 32'h1);
      $display("refusal test done");
   endtask

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      clk_in            = 1'b0;
      rst_in            = 1'b1;
      instr_valid_in    = 1'b0;
      instr_in          = 10'h000;
      timer_ctl_in      = 20'h00000;
      index_in          = 2'h0;
      avs_address_in    = 6'h00;
      avs_read_in       = 1'b0;
      avs_write_in      = 1'b0;
      avs_writedata_in  = 32'h0;
      avs_byteenable_in = 4'h1;
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      #1;
      t_reset();
      t_timer();
      t_moves();
      t_port();
      t_b2b();
      t_refuse();
      end_sim();
   end

   // Guards against a hang outside the bus loop
   initial begin
      #1ms;
      bad_count++;
      end_sim();
   end

endmodule // tb
